// ### core/reob_bank.sv
`timescale 1ns/1ps
module reob_bank (
	// clock and reset
	input  wire logic                                  i_core_clk,
	input  wire logic                                  i_rst_n,
	// register access from the serial management port
	input  wire logic [reob_pkg::ADDR_W-1:0]           i_reg_addr,
	input  wire logic [reob_pkg::DATA_W-1:0]           i_reg_wdata,
	input  wire logic                                  i_reg_wr,
	input  wire logic                                  i_reg_rd,
	output logic      [reob_pkg::DATA_W-1:0]           o_reg_rdata,
	// control input pins, asynchronous
	input  wire logic [reob_pkg::NUM_PINS-1:0]         i_ctl_pin,
	// internal power-good sequencing requests, one per rail
	input  wire logic [reob_pkg::NUM_RAILS-1:0]        i_pg_req,
	// per-rail source: 1 selects a pin, 0 the power-good request
	input  wire logic [reob_pkg::NUM_RAILS-1:0]        i_src_is_pin,
	input  wire logic [reob_pkg::NUM_RAILS*reob_pkg::PIN_IDX_W-1:0] i_src_pin_idx,
	// rail enables
	output logic      [reob_pkg::NUM_STEPDOWN-1:0]     o_stepdown_en,
	output logic                                       o_switch_a1_en,
	output logic                                       o_linreg_a2_en,
	output logic                                       o_term_ldo_en,
	output logic                                       o_switch_b1_en
);
	////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0]                       force_on_q;
	logic [7:0]                       force_on_d;
	logic [7:0]                       force_off_q;
	logic [7:0]                       force_off_d;
	logic [7:0]                       force_off2_q;
	logic [7:0]                       force_off2_d;
	logic [reob_pkg::DATA_W-1:0]      rdata_q;
	logic [reob_pkg::DATA_W-1:0]      rdata_d;
	logic [reob_pkg::NUM_RAILS-1:0]   rail_en_q;
	logic [reob_pkg::NUM_RAILS-1:0]   rail_en_d;
	logic [reob_pkg::NUM_PINS-1:0]    pin_sync;
	logic [reob_pkg::NUM_RAILS-1:0]   rail_req;
	logic [reob_pkg::NUM_RAILS-1:0]   rail_on;
	logic [reob_pkg::NUM_RAILS-1:0]   rail_off_n;

	always_comb begin
		force_on_d   = force_on_q;
		force_off_d  = force_off_q;
		force_off2_d = force_off2_q;
		rdata_d      = rdata_q;
		if (i_reg_wr) begin
			case (i_reg_addr)
				reob_pkg::ADDR_FORCE_ON: begin
					force_on_d = i_reg_wdata;
				end
				reob_pkg::ADDR_FORCE_OFF: begin
					force_off_d = i_reg_wdata & reob_pkg::MASK_FORCE_OFF;
				end
				reob_pkg::ADDR_FORCE_OFF2: begin
					force_off2_d = i_reg_wdata & reob_pkg::MASK_FORCE_OFF2;
				end
				default: begin
					force_on_d = force_on_q;
				end
			endcase
		end
		if (i_reg_rd) begin
			case (i_reg_addr)
				reob_pkg::ADDR_FORCE_ON:   rdata_d = force_on_q;
				reob_pkg::ADDR_FORCE_OFF:  rdata_d = force_off_q;
				reob_pkg::ADDR_FORCE_OFF2: rdata_d = force_off2_q;
				default:                   rdata_d = reob_pkg::RDATA_NONE;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			force_on_q   <= reob_pkg::RST_FORCE_ON;
			force_off_q  <= reob_pkg::RST_FORCE_OFF;
			force_off2_q <= reob_pkg::RST_FORCE_OFF2;
			rdata_q      <= reob_pkg::RDATA_NONE;
		end else begin
			force_on_q   <= force_on_d;
			force_off_q  <= force_off_d;
			force_off2_q <= force_off2_d;
			rdata_q      <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	reob_sync #(
		.WIDTH(reob_pkg::NUM_PINS)
	) u_pin_sync (
		.i_core_clk(i_core_clk),
		.i_rst_n   (i_rst_n),
		.i_async   (i_ctl_pin),
		.o_sync    (pin_sync)
	);

	////////////////////////////////////////////////////////////////////////
	// force-on and force-off vectors by rail
	always_comb begin
		rail_on = '0;
		rail_on[reob_pkg::NUM_OVR-1:0] = force_on_q;
		rail_off_n = '0;
		rail_off_n[reob_pkg::NUM_STEPDOWN-1:0] =
			force_off2_q[reob_pkg::NUM_STEPDOWN-1:0];
		rail_off_n[reob_pkg::RAIL_LOAD_SWITCH_A_ONE]  = force_off_q[reob_pkg::BIT_LOAD_SWITCH_A_ONE_OFF];
		rail_off_n[reob_pkg::RAIL_LINA2] = force_off2_q[reob_pkg::BIT_LINA2_OFF];
		rail_off_n[reob_pkg::RAIL_TERM]  = force_off_q[reob_pkg::BIT_TERM_OFF];
		rail_off_n[reob_pkg::RAIL_LOAD_SWITCH_B_ONE]  = force_off_q[reob_pkg::BIT_LOAD_SWITCH_B_ONE_OFF];
	end

	////////////////////////////////////////////////////////////////////////
	// per-rail request select and enable resolve
	for (genvar r = 0; r < reob_pkg::NUM_RAILS; r++) begin : g_rail
		logic [reob_pkg::PIN_IDX_W-1:0] idx;
		logic                           pin_lvl;
		assign idx     = i_src_pin_idx[r*reob_pkg::PIN_IDX_W +: reob_pkg::PIN_IDX_W];
		// out-of-range pin index reads as no request
		assign pin_lvl = (idx < reob_pkg::PIN_IDX_W'(reob_pkg::NUM_PINS)) ?
			pin_sync[idx] : 1'b0;
		assign rail_req[r] = i_src_is_pin[r] ? pin_lvl : i_pg_req[r];
		// force-off dominates force-on and request
		assign rail_en_d[r] = rail_off_n[r] & (rail_on[r] | rail_req[r]);
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rail_en_q <= '0;
		end else begin
			rail_en_q <= rail_en_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign o_reg_rdata    = rdata_q;
	assign o_stepdown_en  = rail_en_q[reob_pkg::NUM_STEPDOWN-1:0];
	assign o_switch_a1_en = rail_en_q[reob_pkg::RAIL_LOAD_SWITCH_A_ONE];
	assign o_linreg_a2_en = rail_en_q[reob_pkg::RAIL_LINA2];
	assign o_term_ldo_en  = rail_en_q[reob_pkg::RAIL_TERM];
	assign o_switch_b1_en = rail_en_q[reob_pkg::RAIL_LOAD_SWITCH_B_ONE];
endmodule : reob_bank

// ### core/reob_pkg.sv
package reob_pkg;
	localparam int unsigned   ADDR_W        = 8;
	localparam int unsigned   DATA_W        = 8;
	localparam int unsigned   NUM_PINS      = 6;
	localparam int unsigned   PIN_IDX_W     = 3;
	localparam int unsigned   NUM_RAILS     = 10;
	localparam int unsigned   NUM_OVR       = 8;

	// register addresses
	localparam logic [7:0]    ADDR_FORCE_ON = 8'ha0;
	localparam logic [7:0]    ADDR_FORCE_OFF = 8'h9f;
	localparam logic [7:0]    ADDR_FORCE_OFF2 = 8'h9e;

	// reset values
	localparam logic [7:0]    RST_FORCE_ON  = 8'h00;
	localparam logic [7:0]    RST_FORCE_OFF = 8'h70;
	localparam logic [7:0]    RST_FORCE_OFF2 = 8'hbf;

	// writable masks, unimplemented bits read zero
	localparam logic [7:0]    MASK_FORCE_OFF = 8'h7f;
	localparam logic [7:0]    MASK_FORCE_OFF2 = 8'hbf;
	localparam logic [7:0]    RDATA_NONE    = 8'h00;

	// force-off register field positions
	localparam int unsigned   BIT_LOAD_SWITCH_B_ONE_OFF  = 6;
	localparam int unsigned   BIT_LOAD_SWITCH_A_ONE_OFF  = 5;
	localparam int unsigned   BIT_TERM_OFF  = 4;
	// second force-off register field positions
	localparam int unsigned   BIT_LINA2_OFF = 7;

	// rail indices on the enable vector
	localparam int unsigned   RAIL_LOAD_SWITCH_A_ONE     = 6;
	localparam int unsigned   RAIL_LINA2    = 7;
	localparam int unsigned   RAIL_TERM     = 8;
	localparam int unsigned   RAIL_LOAD_SWITCH_B_ONE     = 9;
	localparam int unsigned   NUM_STEPDOWN  = 6;
endpackage : reob_pkg

// ### core/reob_sync.sv
`timescale 1ns/1ps
module reob_sync #(
	parameter int unsigned WIDTH = 1
) (
	// clock and reset
	input  wire logic             i_core_clk,
	input  wire logic             i_rst_n,
	// asynchronous in, synchronous out
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;
endmodule : reob_sync

// ### verif/reob_props.sv
`timescale 1ns/1ps
module reob_props (
	input  wire logic       i_core_clk,
	input  wire logic       i_rst_n,
	input  wire logic [7:0] i_reg_addr,
	input  wire logic [7:0] i_reg_wdata,
	input  wire logic       i_reg_wr,
	input  wire logic       i_reg_rd,
	input  wire logic [7:0] o_reg_rdata,
	input  wire logic [9:0] i_pg_req,
	input  wire logic [9:0] i_src_is_pin,
	input  wire logic [5:0] o_stepdown_en,
	input  wire logic       o_switch_a1_en,
	input  wire logic       o_linreg_a2_en,
	input  wire logic       o_term_ldo_en,
	input  wire logic       o_switch_b1_en
);
	logic [7:0] on_q, off_q, off2_q;
	logic [9:0] off_v, exp_v, en_v;
	// shadow of the register file, rail order
	assign off_v = {off_q[6], off_q[4], off2_q[7], off_q[5], off2_q[5:0]};
	assign exp_v = off_v & ({2'h0, on_q} | i_pg_req);
	assign en_v  = {o_switch_b1_en, o_term_ldo_en, o_linreg_a2_en, o_switch_a1_en, o_stepdown_en};
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			on_q   <= reob_pkg::RST_FORCE_ON;
			off_q  <= reob_pkg::RST_FORCE_OFF;
			off2_q <= reob_pkg::RST_FORCE_OFF2;
		end else if (i_reg_wr) begin
			if (i_reg_addr == 8'ha0) on_q <= i_reg_wdata;
			if (i_reg_addr == 8'h9f) off_q <= i_reg_wdata & reob_pkg::MASK_FORCE_OFF;
			if (i_reg_addr == 8'h9e) off2_q <= i_reg_wdata & reob_pkg::MASK_FORCE_OFF2;
		end
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	chk_stepdown_resolve: assert property (
		$past(i_src_is_pin[5:0]) == 6'h00 |-> o_stepdown_en == $past(exp_v[5:0]))
		else $error("stepdown");
	chk_switch_a1_gate: assert property (
		!$past(i_src_is_pin[6]) |-> o_switch_a1_en == $past(exp_v[6])) else $error("switch a1");
	chk_linreg_gate: assert property (
		!$past(i_src_is_pin[7]) |-> o_linreg_a2_en == $past(exp_v[7])) else $error("linreg a2");
	chk_term_ldo_gate: assert property (
		!$past(i_src_is_pin[8]) |-> o_term_ldo_en == $past(exp_v[8])) else $error("term ldo");
	chk_switch_b1_gate: assert property (
		!$past(i_src_is_pin[9]) |-> o_switch_b1_en == $past(exp_v[9])) else $error("switch b1");
	chk_off_dominates: assert property (
		(en_v & ~$past(off_v)) == 10'h000) else $error("force-off ignored");
	chk_override_read: assert property (
		i_reg_rd && i_reg_addr == 8'ha0 |=> o_reg_rdata == $past(on_q))
		else $error("override read");
	chk_rdata_hold: assert property (
		!i_reg_rd |=> $stable(o_reg_rdata)) else $error("read data moved");
endmodule : reob_props
bind reob_bank reob_props u_chk (.i_core_clk, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
	.i_reg_rd, .o_reg_rdata, .i_pg_req, .i_src_is_pin, .o_stepdown_en, .o_switch_a1_en,
	.o_linreg_a2_en, .o_term_ldo_en, .o_switch_b1_en);

// ### verif/reob_bank_test.sv
`timescale 1ns/1ps
module reob_bank_test;
	logic i_core_clk = 1'h0, i_rst_n = 1'h0, i_reg_wr = 1'h0, i_reg_rd = 1'h0;
	logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
	logic [5:0] i_ctl_pin = 6'h00, o_stepdown_en;
	logic [9:0] i_pg_req = 10'h000, i_src_is_pin = 10'h000;
	logic [29:0] i_src_pin_idx = 30'h3fffffff;
	logic o_switch_a1_en, o_linreg_a2_en, o_term_ldo_en, o_switch_b1_en;
	int miscompares = 0, checked = 0;
	always #10 i_core_clk = ~i_core_clk;
	reob_bank dut (.i_core_clk, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
		.o_reg_rdata, .i_ctl_pin, .i_pg_req, .i_src_is_pin, .i_src_pin_idx, .o_stepdown_en,
		.o_switch_a1_en, .o_linreg_a2_en, .o_term_ldo_en, .o_switch_b1_en);
	task automatic cyc(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask : cyc
	task automatic fail(input string s);
		miscompares++;
		$display("[ERR] %0t %s", $time, s);
	endtask : fail
	task automatic cmp_data(input logic [7:0] e);
		checked++;
		if (o_reg_rdata !== e) fail($sformatf("rdata %h exp %h", o_reg_rdata, e));
	endtask : cmp_data
	task automatic cmp_en(input logic [9:0] e);
		checked++;
		if ({o_switch_b1_en, o_term_ldo_en, o_linreg_a2_en, o_switch_a1_en, o_stepdown_en} !== e)
			fail($sformatf("enables wrong, exp %h", e));
	endtask : cmp_en
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_reg_addr = a;
		i_reg_wdata = d;
		i_reg_wr = 1'h1;
		cyc(1);
		i_reg_wr = 1'h0;
		cyc(1);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		i_reg_addr = a;
		i_reg_rd = 1'h1;
		cyc(1);
		i_reg_rd = 1'h0;
		cmp_data(e);
		cyc(1);
	endtask : rd
	task automatic give_verdict;
		$display("mismatches %0d of %0d checks", miscompares, checked);
		if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	initial begin
		#20000;
		miscompares++;
		give_verdict();
	end
	initial begin
		cyc(10);
		i_rst_n = 1'h1;
		cyc(2);
		rd(8'ha0, 8'h00);
		rd(8'h9f, 8'h70);
		rd(8'h9e, 8'hbf);
		rd(8'h55, 8'h00);
		i_pg_req = 10'h3ff;
		cyc(2);
		cmp_en(10'h3ff);
		wr(8'h9f, 8'h60);
		cyc(1);
		cmp_en(10'h2ff);
		wr(8'h9f, 8'h50);
		cyc(1);
		cmp_en(10'h3bf);
		wr(8'h9f, 8'h30);
		cyc(1);
		cmp_en(10'h1ff);
		wr(8'h9f, 8'h80);
		cyc(1);
		cmp_en(10'h0bf);
		rd(8'h9f, 8'h00);
		i_pg_req = 10'h000;
		wr(8'h9f, 8'h70);
		for (int i = 0; i < 8; i++) begin
			wr(8'ha0, 8'h01 << i);
			cyc(1);
			cmp_en(10'h001 << i);
		end
		wr(8'ha0, 8'hff);
		rd(8'ha0, 8'hff);
		wr(8'h9e, 8'h40);
		wr(8'h9f, 8'h00);
		cyc(1);
		cmp_en(10'h000);
		rd(8'h9e, 8'h00);
		wr(8'h9e, 8'hbf);
		wr(8'h9f, 8'h70);
		wr(8'ha0, 8'h00);
		i_src_is_pin = 10'h001;
		i_src_pin_idx = {{9{3'h7}}, 3'h2};
		i_ctl_pin = 6'h04;
		cyc(3);
		cmp_en(10'h001);
		i_ctl_pin = 6'h00;
		cyc(3);
		cmp_en(10'h000);
		give_verdict();
	end
endmodule : reob_bank_test
